// ===== rtl/sdm_pkg.sv
// Shared constants and types for the delta-sigma bitstream link
// Notes on behaviour
// - Filter end drives clock and sync, reads stream
// - Each channel becomes a one-bit oversampled stream
// - One output bit per four modulator clocks
// - Ones density tracks input, 14 to 86 percent
// - Corrected codes: 5D1420, 000000, A2EBE0 at references
// - Uncorrected codes shift by internal offset
// - Correction subtracts amplifier and internal offset
// - Sync rising edge restarts conversion state
// - Filter issues sync pulse after system sync
// - Tone offset pin adds negative per-channel offset
// - Loop instability beyond full scale is detected
// - Instability drops to first order, raises flag
// - Recovery needs 32 in-range modulator clocks
// - Sustained over-range makes the flag pulse
// - Sync latched on falling edge, acts next rising
// - Roughly 40 us without clock edges powers down
// - Power-down pin high disables, outputs released
package sdm_pkg;
    // System and modulator clock
    localparam int CLK_HZ        = 100_000_000;
    localparam int MOD_HZ        = 2_048_000;
    localparam int DIV_HALF      = CLK_HZ / (2 * MOD_HZ);
    localparam int PHASES        = 4;
    localparam int BIT_RATE_KBPS = 512;
    // Loss-of-clock and recovery timing
    localparam int LOSS_US       = 40;
    localparam int LOSS_CYC      = LOSS_US * (CLK_HZ / 1_000_000);
    localparam int RECOVER_CYC   = 32;
    // Channels and input scaling
    localparam int MAX_CH        = 2;
    localparam int SMP_W         = 16;
    localparam int FS_CODE       = 24576;
    localparam int VREF_MV       = 2500;
    localparam int OFS_CH1_MV    = 60;
    localparam int OFS_CH2_MV    = 35;
    localparam int DENS_POS_PCT  = 86;
    localparam int FB_LEVEL      = FS_CODE * 50 / (DENS_POS_PCT - 50);
    localparam int STAB_LIMIT    = FB_LEVEL * 16;
    // Decimation and output coding
    localparam int DECIM         = 512;
    localparam int WORD_W        = 24;
    localparam int GAIN_SHIFT    = 8;
    localparam logic [23:0] CODE_POS_FS = 24'h5D1420;
    localparam logic [23:0] CODE_NEG_FS = 24'hA2EBE0;
    localparam longint CODE_GAIN = (longint'(CODE_POS_FS) << GAIN_SHIFT) * 100
                                   / longint'(DECIM * (2 * DENS_POS_PCT - 100));
    // Loop order, power and sync states
    typedef enum logic [1:0] {ORD_FOURTH = 2'b01, ORD_FIRST = 2'b10} sdm_order_t;
    typedef enum logic [2:0] {PWR_OFF = 3'b001, PWR_RUN = 3'b010, PWR_LOST = 3'b100} sdm_pwr_t;
    typedef enum logic [2:0] {SY_IDLE = 3'b001, SY_WAIT = 3'b010, SY_DRIVE = 3'b100} sdm_sync_t;
endpackage

// ===== rtl/sdm_link_if.sv
// Link between modulator end and filter end
`timescale 1ns/1ps
`default_nettype none
interface sdm_link_if #(parameter int CH = sdm_pkg::MAX_CH);
    logic          modclk;
    logic          sample_sync;
    logic [CH-1:0] bit_o;
    logic [CH-1:0] bit_oe;
    logic [CH-1:0] flag_o;
    logic [CH-1:0] flag_oe;
    logic [CH-1:0] bitstream;
    logic [CH-1:0] overrange_flag_out;
    // Released pins read low, as with a weak pull-down
    assign bitstream          = bit_o & bit_oe;
    assign overrange_flag_out = flag_o & flag_oe;
    modport dev (input modclk, input sample_sync,
                 output bit_o, output bit_oe, output flag_o, output flag_oe);
    modport flt (output modclk, output sample_sync,
                 input bitstream, input overrange_flag_out);
endinterface
`default_nettype wire

// ===== rtl/sdm_loop.sv
// One channel of the modulator loop with stability supervision
`timescale 1ns/1ps
`default_nettype none
module sdm_loop
#(
    parameter int W = sdm_pkg::SMP_W
)
(
    // Clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_rst,
    // Timing from the owning end
    input  wire logic                i_restart,
    input  wire logic                i_tick,
    input  wire logic                i_step,
    // Sample and results
    input  wire logic signed [W-1:0] i_x,
    output logic                     o_bit,
    output logic                     o_unstable
);
    import sdm_pkg::*;
    localparam int IW = W + 8;
    localparam logic signed [IW-1:0] FB  = IW'(FB_LEVEL);
    localparam logic signed [IW-1:0] LIM = IW'(STAB_LIMIT);
    localparam logic signed [W-1:0]  FSX = W'(FS_CODE);
    localparam logic [5:0]           REC_LAST = 6'(RECOVER_CYC - 1);

    if (W < 16 || W > 24)
    begin : g_bad_width
        $error("sdm_loop: sample width out of range");
    end

    function automatic logic beyond(input logic signed [IW-1:0] v);
        return (v > LIM) || (v < -LIM);
    endfunction

    logic signed [IW-1:0] int_reg [4];
    logic signed [IW-1:0] int_next [4];
    sdm_order_t           ord_reg, ord_next;
    logic                 bit_reg, bit_next;
    logic [5:0]           rec_reg, rec_next;
    logic                 rng_reg, rng_next;
    logic                 in_range;
    logic signed [IW-1:0] fb, s1, s2, s3, s4, q;

    always_comb
    begin
        in_range = (i_x <= FSX) && (i_x >= -FSX);
        fb       = bit_reg ? FB : -FB;
        s1       = int_reg[0] + IW'(i_x) - fb;
        s2       = int_reg[1] + s1 - fb;
        s3       = int_reg[2] + (s2 >>> 2) - (fb >>> 2);
        s4       = int_reg[3] + (s3 >>> 2) - (fb >>> 2);
        q        = s2 + (s3 >>> 3) + (s4 >>> 5);
        int_next = int_reg;
        ord_next = ord_reg;
        bit_next = bit_reg;
        rec_next = rec_reg;
        rng_next = rng_reg;
        if (i_restart)
        begin
            int_next = '{default: '0};
            ord_next = ORD_FOURTH;
            rec_next = '0;
        end
        else
        begin
            case (ord_reg)
                ORD_FOURTH:
                    if (i_step)
                    begin
                        if (beyond(s1) || beyond(s2) || beyond(s3) || beyond(s4))
                        begin
                            ord_next = ORD_FIRST;
                            int_next = '{default: '0};
                            rec_next = '0;
                        end
                        else
                        begin
                            int_next = '{s1, s2, s3, s4};
                            bit_next = ~q[IW-1];
                        end
                    end
                ORD_FIRST:
                begin
                    // Counts ticks of one kind; a change of range restarts it
                    if (i_tick)
                    begin
                        rng_next = in_range;
                        rec_next = (in_range == rng_reg) ? rec_reg + 6'h01 : 6'h00;
                    end
                    if (i_tick && in_range == rng_reg && rec_reg == REC_LAST)
                    begin
                        // In range recovers; persistent over-range retries and trips again
                        ord_next = ORD_FOURTH;
                        int_next = '{default: '0};
                        rec_next = '0;
                    end
                    else if (i_step)
                    begin
                        int_next[0] = s1;
                        bit_next    = ~s1[IW-1];
                    end
                end
                default: ord_next = ORD_FOURTH;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            int_reg <= '{default: '0};
            ord_reg <= ORD_FOURTH;
            bit_reg <= 1'b0;
            rec_reg <= '0;
            rng_reg <= 1'b0;
        end
        else
        begin
            int_reg <= int_next;
            ord_reg <= ord_next;
            bit_reg <= bit_next;
            rec_reg <= rec_next;
            rng_reg <= rng_next;
        end
    end

    assign o_bit      = bit_reg;
    assign o_unstable = (ord_reg == ORD_FIRST);
endmodule
`default_nettype wire

// ===== rtl/sdm_modulator.sv
// Modulator end: bit timing, sync, power control and clock-loss watch
`timescale 1ns/1ps
`default_nettype none
module sdm_modulator
#(
    parameter int CH = sdm_pkg::MAX_CH,
    parameter int W  = sdm_pkg::SMP_W
)
(
    // Clock and reset
    input  wire logic            i_mclk,
    input  wire logic            i_rst,
    // Link to the filter end
    sdm_link_if.dev              link,
    // Input samples, signed, channel 0 in the low bits
    input  wire logic [CH*W-1:0] i_sample,
    // Control pins
    input  wire logic            i_power_down_pin,
    input  wire logic            i_tone_offset_enable,
    // Status
    output logic                 o_active,
    output logic [CH-1:0]        o_overrange
);
    import sdm_pkg::*;
    localparam logic [12:0] LOSS_LAST  = 13'(LOSS_CYC - 1);
    localparam logic [1:0]  PHASE_LAST = 2'(PHASES - 1);

    if (CH < 1 || CH > MAX_CH)
    begin : g_bad_ch
        $error("sdm_modulator: channel count not supported");
    end
    if (LOSS_CYC > 8191)
    begin : g_bad_loss
        $error("sdm_modulator: loss counter too narrow");
    end

    // Idle-tone offset in input codes
    function automatic logic signed [W:0] shifted(input logic signed [W-1:0] x,
                                                  input int ch, input logic en);
        int mv;
        mv = (ch == 0) ? OFS_CH1_MV : OFS_CH2_MV;
        if (!en)
            return (W+1)'(x);
        return (W+1)'(x) - (W+1)'(FS_CODE * mv / VREF_MV);
    endfunction

    // Edge detection on the incoming modulator clock
    logic clk_prev_reg, clk_prev_next;
    logic rise, fall;

    // Sync capture
    logic sync_smp_reg, sync_smp_next;
    logic pend_reg, pend_next;
    logic instant;

    // Phase and power
    logic [1:0]  phase_reg, phase_next;
    logic [12:0] idle_reg, idle_next;
    sdm_pwr_t    pwr_reg, pwr_next;
    logic        run, step, restart;

    // Pin registers
    logic [CH-1:0] bit_out_reg, bit_out_next;
    logic [CH-1:0] flag_out_reg, flag_out_next;
    logic          oe_reg, oe_next;
    logic [CH-1:0] ovr_reg, ovr_next;

    // Loop results
    logic [CH-1:0] core_bit;
    logic [CH-1:0] core_unstable;

    always_comb
    begin
        clk_prev_next = link.modclk;
        rise          = link.modclk & ~clk_prev_reg;
        fall          = ~link.modclk & clk_prev_reg;
        run           = (pwr_reg == PWR_RUN);
        instant       = rise & pend_reg;
        restart       = instant | ~run;
        step          = rise & ~pend_reg & run & (phase_reg == PHASE_LAST);
    end

    // Sync: latch on falling edge, act on the next rising edge
    always_comb
    begin
        sync_smp_next = sync_smp_reg;
        pend_next     = pend_reg;
        if (instant)
            pend_next = 1'b0;
        if (fall)
        begin
            sync_smp_next = link.sample_sync;
            if (link.sample_sync && !sync_smp_reg && run)
                pend_next = 1'b1;
        end
    end

    // Divide-by-four bit phase
    always_comb
    begin
        phase_next = phase_reg;
        if (restart)
            phase_next = '0;
        else if (rise)
            phase_next = phase_reg + 2'h1;
    end

    // Power modes and loss of clock
    always_comb
    begin
        idle_next = idle_reg;
        pwr_next  = pwr_reg;
        if (rise || fall)
            idle_next = '0;
        else if (idle_reg != LOSS_LAST)
            idle_next = idle_reg + 13'h0001;
        case (pwr_reg)
            PWR_RUN:
                if (idle_reg == LOSS_LAST)
                    pwr_next = PWR_LOST;
                else if (i_power_down_pin)
                    pwr_next = PWR_OFF;
            PWR_OFF:
                if (idle_reg == LOSS_LAST)
                    pwr_next = PWR_LOST;
                else if (!i_power_down_pin)
                    pwr_next = PWR_RUN;
            PWR_LOST:
                // Pin is ignored until the clock returns
                if (rise || fall)
                    pwr_next = PWR_OFF;
            default: pwr_next = PWR_OFF;
        endcase
    end

    // Output pins; released whenever not converting
    always_comb
    begin
        oe_next       = run;
        bit_out_next  = run ? core_bit : '0;
        flag_out_next = run ? core_unstable : '0;
        ovr_next      = run ? core_unstable : '0;
    end

    for (genvar c = 0; c < CH; c++)
    begin : g_ch
        sdm_loop #(
            .W (W + 1)
        ) u_loop (
            .i_mclk     (i_mclk),
            .i_rst      (i_rst),
            .i_restart  (restart),
            .i_tick     (rise),
            .i_step     (step),
            .i_x        (shifted(i_sample[c*W +: W], c, i_tone_offset_enable)),
            .o_bit      (core_bit[c]),
            .o_unstable (core_unstable[c])
        );
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            clk_prev_reg <= 1'b0;
            sync_smp_reg <= 1'b0;
            pend_reg     <= 1'b0;
            phase_reg    <= '0;
            idle_reg     <= '0;
            pwr_reg      <= PWR_OFF;
            oe_reg       <= 1'b0;
            bit_out_reg  <= '0;
            flag_out_reg <= '0;
            ovr_reg      <= '0;
        end
        else
        begin
            clk_prev_reg <= clk_prev_next;
            sync_smp_reg <= sync_smp_next;
            pend_reg     <= pend_next;
            phase_reg    <= phase_next;
            idle_reg     <= idle_next;
            pwr_reg      <= pwr_next;
            oe_reg       <= oe_next;
            bit_out_reg  <= bit_out_next;
            flag_out_reg <= flag_out_next;
            ovr_reg      <= ovr_next;
        end
    end

    // Same enable on every pin so a powered-down part frees the whole bus
    assign link.bit_o   = bit_out_reg;
    assign link.bit_oe  = {CH{oe_reg}};
    assign link.flag_o  = flag_out_reg;
    assign link.flag_oe = {CH{oe_reg}};
    assign o_active     = oe_reg;
    assign o_overrange  = ovr_reg;
endmodule
`default_nettype wire

// ===== rtl/sdm_filter_end.sv
// Filter end: makes clock and sync, decimates the bitstream to words
`timescale 1ns/1ps
`default_nettype none
module sdm_filter_end
#(
    parameter int CH = sdm_pkg::MAX_CH
)
(
    // Clock and reset
    input  wire logic                            i_mclk,
    input  wire logic                            i_rst,
    // Link to the modulator end
    sdm_link_if.flt                              link,
    // System control
    input  wire logic                            i_clk_en,
    input  wire logic                            i_sync,
    input  wire logic                            i_ofs_corr_en,
    input  wire logic [CH*sdm_pkg::WORD_W-1:0]   i_ofs_code,
    // Results
    output logic [CH*sdm_pkg::WORD_W-1:0]        o_word,
    output logic                                 o_word_valid,
    output logic [CH-1:0]                        o_word_flag,
    output logic [CH-1:0]                        o_overrange
);
    import sdm_pkg::*;
    localparam logic [5:0]         DIV_LAST = 6'(DIV_HALF - 1);
    localparam logic [8:0]         DEC_LAST = 9'(DECIM - 1);
    localparam logic signed [35:0] GAIN     = 36'(CODE_GAIN);

    if (CH < 1 || CH > MAX_CH || DIV_HALF > 63 || DECIM != 512)
    begin : g_bad_cfg
        $error("sdm_filter_end: configuration not supported");
    end

    // Ones minus zeros, scaled to full-scale output code
    function automatic logic [WORD_W-1:0] scale(input logic signed [10:0] acc);
        logic signed [35:0] p;
        p = 36'(acc) * GAIN;
        return p[GAIN_SHIFT +: WORD_W];
    endfunction

    logic [5:0]             div_reg, div_next;
    logic                   clk_reg, clk_next;
    logic                   rise;
    sdm_sync_t              sy_reg, sy_next;
    logic                   ms_reg, ms_next;
    logic                   instant;
    logic [1:0]             phase_reg, phase_next;
    logic [8:0]             cnt_reg, cnt_next;
    logic signed [10:0]     acc_reg [CH];
    logic signed [10:0]     acc_next [CH];
    logic signed [10:0]     acc_add;
    logic [CH-1:0]          stick_reg, stick_next;
    logic [CH*WORD_W-1:0]   word_reg, word_next;
    logic                   val_reg, val_next;
    logic [CH-1:0]          wflag_reg, wflag_next;
    logic [CH-1:0]          ovr_reg, ovr_next;

    // Clock divider and sync pulse
    always_comb
    begin
        div_next = div_reg;
        clk_next = clk_reg;
        rise     = 1'b0;
        if (i_clk_en)
        begin
            div_next = (div_reg == DIV_LAST) ? 6'h00 : div_reg + 6'h01;
            if (div_reg == DIV_LAST)
            begin
                clk_next = ~clk_reg;
                rise     = ~clk_reg;
            end
        end
        sy_next = sy_reg;
        ms_next = ms_reg;
        instant = 1'b0;
        case (sy_reg)
            SY_IDLE:
                if (i_sync)
                    sy_next = SY_WAIT;
            SY_WAIT:
                if (rise)
                begin
                    ms_next = 1'b1;
                    sy_next = SY_DRIVE;
                end
            SY_DRIVE:
                // Held one modulator period so one falling edge sees it
                if (rise)
                begin
                    ms_next = 1'b0;
                    instant = 1'b1;
                    sy_next = SY_IDLE;
                end
            default: sy_next = SY_IDLE;
        endcase
    end

    // Bit recovery and decimation
    always_comb
    begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        acc_next   = acc_reg;
        stick_next = stick_reg | link.overrange_flag_out;
        word_next  = word_reg;
        val_next   = 1'b0;
        wflag_next = wflag_reg;
        ovr_next   = link.overrange_flag_out;
        acc_add    = '0;
        if (instant)
        begin
            phase_next = '0;
            cnt_next   = '0;
            acc_next   = '{default: '0};
        end
        else if (rise)
        begin
            phase_next = phase_reg + 2'h1;
            // Mid-bit sample, well clear of the modulator's update
            if (phase_reg == 2'h1)
            begin
                cnt_next = (cnt_reg == DEC_LAST) ? 9'h000 : cnt_reg + 9'h001;
                for (int c = 0; c < CH; c++)
                begin
                    acc_add = acc_reg[c] + (link.bitstream[c] ? 11'sh001 : -11'sh001);
                    acc_next[c] = acc_add;
                    if (cnt_reg == DEC_LAST)
                    begin
                        word_next[c*WORD_W +: WORD_W] = scale(acc_add)
                            - (i_ofs_corr_en ? i_ofs_code[c*WORD_W +: WORD_W] : '0);
                        acc_next[c] = '0;
                    end
                end
                if (cnt_reg == DEC_LAST)
                begin
                    val_next   = 1'b1;
                    wflag_next = stick_reg | link.overrange_flag_out;
                    // A flag in the clearing cycle still sticks for the next word
                    stick_next = link.overrange_flag_out;
                end
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            div_reg   <= '0;
            clk_reg   <= 1'b0;
            sy_reg    <= SY_IDLE;
            ms_reg    <= 1'b0;
            phase_reg <= '0;
            cnt_reg   <= '0;
            acc_reg   <= '{default: '0};
            stick_reg <= '0;
            word_reg  <= '0;
            val_reg   <= 1'b0;
            wflag_reg <= '0;
            ovr_reg   <= '0;
        end
        else
        begin
            div_reg   <= div_next;
            clk_reg   <= clk_next;
            sy_reg    <= sy_next;
            ms_reg    <= ms_next;
            phase_reg <= phase_next;
            cnt_reg   <= cnt_next;
            acc_reg   <= acc_next;
            stick_reg <= stick_next;
            word_reg  <= word_next;
            val_reg   <= val_next;
            wflag_reg <= wflag_next;
            ovr_reg   <= ovr_next;
        end
    end

    assign link.modclk      = clk_reg;
    assign link.sample_sync = ms_reg;
    assign o_word           = word_reg;
    assign o_word_valid     = val_reg;
    assign o_word_flag      = wflag_reg;
    assign o_overrange      = ovr_reg;
endmodule
`default_nettype wire

// ===== tb/sdm_link_checker.sv
// Assertions on the link between modulator end and filter end
`timescale 1ns/1ps
`default_nettype none
module sdm_link_checker
    import sdm_pkg::*;
#(parameter int CH = MAX_CH)
(
    // Clock and reset
    input wire logic          i_mclk,
    input wire logic          i_rst,
    // Link signals
    input wire logic          modclk,
    input wire logic          sample_sync,
    input wire logic [CH-1:0] bit_o,
    input wire logic [CH-1:0] bit_oe,
    input wire logic [CH-1:0] flag_o,
    input wire logic [CH-1:0] flag_oe
);
    logic [12:0] idle_reg;
    logic [12:0] idle_next;
    logic [7:0]  rise_reg;
    logic [7:0]  rise_next;
    logic        mclk_reg;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Saturating, so a long stop cannot wrap back to zero
    always_comb
    begin
        idle_next = (modclk != mclk_reg) ? 13'h0 : idle_reg + 13'(idle_reg != 13'h1FFF);
        rise_next = (!flag_o[0] || sample_sync) ? 8'h0 : rise_reg + 8'(modclk && !mclk_reg && rise_reg != 8'hFF);
    end
    always_ff @(posedge i_mclk)
    begin
        mclk_reg <= modclk;
        idle_reg <= i_rst ? 13'h0 : idle_next;
        rise_reg <= i_rst ? 8'h0 : rise_next;
    end
    property p_clk_hi; $rose(modclk) |=> modclk [*8]; endproperty
    a_clk_hi: assert property (p_clk_hi) else $error("modclk high phase too short");
    property p_bit_t; $changed(bit_o) && bit_oe[0] && $past(bit_oe[0])
        |-> $past(modclk, 2) && !$past(modclk, 3) || $past(modclk) && !$past(modclk, 2); endproperty
    a_bit_t: assert property (p_bit_t) else $error("bit changed away from a clock rise");
    property p_flag_t; $changed(flag_o) && flag_oe[0] && $past(flag_oe[0])
        |-> $past(modclk, 2) && !$past(modclk, 3) || $past(modclk) && !$past(modclk, 2); endproperty
    a_flag_t: assert property (p_flag_t) else $error("flag changed away from a clock rise");
    property p_sync_len; $rose(sample_sync) |=> sample_sync [*8]; endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync pulse too short");
    property p_sync_clk; $rose(sample_sync) |-> modclk; endproperty
    a_sync_clk: assert property (p_sync_clk) else $error("sync rose while clock low");
    property p_loss; idle_reg >= LOSS_CYC + 8 |-> bit_oe == '0 && flag_oe == '0; endproperty
    a_loss: assert property (p_loss) else $error("pins driven with clock stopped");
    property p_oe_pair; bit_oe == flag_oe; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("pin enables disagree");
    property p_recover; $fell(flag_o[0]) && flag_oe[0] && $past(flag_oe[0]) |-> $past(rise_reg) >= 31; endproperty
    a_recover: assert property (p_recover) else $error("flag cleared too early");
endmodule
`default_nettype wire

// ===== tb/sigma_delta_bitstream_iface_bench.sv
// Bench joining modulator end and filter end over the link
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_bitstream_iface_bench;
    import sdm_pkg::*;
    logic        i_mclk;
    logic        i_rst;
    logic [31:0] smp;
    logic        pd;
    logic        tone;
    logic        clk_en;
    logic        sync_req;
    logic        active;
    logic [1:0]  ovr;
    logic [1:0]  f_ovr;
    logic        fl_d = 1'b0;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          rises = 0;
    int          ones0;
    int          ones1;
    int          base;
    int          pct [3] = '{50, DENS_POS_PCT, 100 - DENS_POS_PCT};
    logic [15:0] lvl [3] = '{16'h0000, 16'h6000, 16'hA000};
    sdm_link_if #(.CH(2)) link ();
    sdm_modulator u_sdm_modulator (.i_mclk(i_mclk), .i_rst(i_rst), .link(link), .i_sample(smp),
        .i_power_down_pin(pd), .i_tone_offset_enable(tone), .o_active(active), .o_overrange(ovr));
    sdm_filter_end u_sdm_filter_end (.i_mclk(i_mclk), .i_rst(i_rst), .link(link), .i_clk_en(clk_en),
        .i_sync(sync_req), .i_ofs_corr_en(1'b1), .i_ofs_code(48'h0), .o_word(), .o_word_valid(),
        .o_word_flag(), .o_overrange(f_ovr));
    sdm_link_checker #(.CH(2)) u_sdm_link_checker (.i_mclk(i_mclk), .i_rst(i_rst), .modclk(link.modclk),
        .sample_sync(link.sample_sync), .bit_o(link.bit_o), .bit_oe(link.bit_oe),
        .flag_o(link.flag_o), .flag_oe(link.flag_oe));
    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Flag pulse count; a hung wait ends in the closing report
    always @(posedge i_mclk)
    begin
        fl_d <= link.overrange_flag_out[0];
        rises <= rises + int'(link.overrange_flag_out[0] && !fl_d);
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, input int lo, input int hi);
        n_compared++;
        if (^got === 1'bx || got < lo || got > hi)
        begin
            error_cnt++;
            $display("wrong value t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    // One sample per bit period, clear of the change point
    task automatic bits(input int n);
        ones0 = 0;
        ones1 = 0;
        repeat (n)
        begin
            repeat (4) @(posedge link.modclk);
            repeat (10) @(posedge i_mclk);
            ones0 += int'(link.bitstream[0]);
            ones1 += int'(link.bitstream[1]);
        end
    endtask
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {i_rst, smp, pd, tone, clk_en, sync_req} = {1'b1, 36'h0};
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        pd <= 1'b1;
        clk_en <= 1'b1;
        repeat (200) @(posedge i_mclk);
        check({active, link.bit_oe, link.flag_oe}, 0, 0);
        pd <= 1'b0;
        repeat (200) @(posedge i_mclk);
        check({active, link.bit_oe, link.flag_oe}, 31, 31);
        sync_req <= 1'b1;
        @(posedge i_mclk);
        sync_req <= 1'b0;
        for (int i = 0; i < 200 && !link.sample_sync; i++)
            @(posedge i_mclk);
        check(link.sample_sync, 1, 1);
        for (int i = 0; i < 200 && link.sample_sync; i++)
            @(posedge i_mclk);
        check(link.sample_sync, 0, 0);
        // Settle, then count ones at mid, plus and minus full scale
        for (int k = 0; k < 3; k++)
        begin
            smp <= {2{lvl[k]}};
            bits(16);
            bits(64);
            check(ones0, pct[k] * 64 / 100 - 6, pct[k] * 64 / 100 + 6);
            check(ones1, pct[k] * 64 / 100 - 6, pct[k] * 64 / 100 + 6);
        end
        tone <= 1'b1;
        smp <= {2{16'h7FFF}};
        base = rises;
        bits(100);
        check(rises - base, 2, 255);
        smp <= 32'h0;
        bits(24);
        check({ovr, f_ovr, link.overrange_flag_out}, 0, 0);
        clk_en <= 1'b0;
        repeat (LOSS_CYC + 100) @(posedge i_mclk);
        check({active, link.bit_oe}, 0, 0);
        clk_en <= 1'b1;
        repeat (300) @(posedge i_mclk);
        check(active, 1, 1);
        conclude();
    end
endmodule
`default_nettype wire
